/* bench/fpsc_host_model.sv */
// Purpose: host side of the serial link: clock, data and load strobe
// Assumes: clk is the 50 MHz core clock; serial clock period 160 ns when sending, 240 ns when reading
// Notes: serial clock stands low between frames; data inverted when let go
`timescale 1ns/1ps
`default_nettype none
module fpsc_host_model (
   input wire logic clk,
   input wire logic lineIn,
   output logic serClk,
   output logic hostData,
   output logic load
);
   initial begin
      serClk = 1'b0;
      hostData = 1'b0;
      load = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask

   // -----------------------------------------------
   // transfers
   // -----------------------------------------------
   // msb first, display bits then command bits
   task automatic send(input logic [44:0] v, input int n);
      // each clock level lasts 4 clk so the pin synchronisers never miss an edge
      for (int i = n - 1; i >= 0; i--) begin
         hostData <= v[i];
         wait_clk(4);
         serClk <= 1'b1;
         wait_clk(4);
         serClk <= 1'b0;
      end
      hostData <= ~v[0];
   endtask

   task automatic strobe();
      load <= 1'b1;
      wait_clk(8);
      load <= 1'b0;
      wait_clk(8);
   endtask

   // bit shows a few cycles after the rise, sampled well after
   task automatic read(output logic [29:0] v);
      for (int i = 29; i >= 0; i--) begin
         serClk <= 1'b1;
         wait_clk(6);
         v[i] = lineIn;
         wait_clk(2);
         serClk <= 1'b0;
         wait_clk(4);
      end
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench of the front-panel serial command port
// Assumes: host model drives the link; bench answers the key scan
// Notes: display side stalls while frames queue up
`timescale 1ns/1ps
`default_nettype none
module tb
   import fpsc_pkg::*;
;
   // -----------------------------------------------
   // signals
   // -----------------------------------------------
   logic clk, rst, serClk, hostData, load, lineIn, serDataOut, serDataOe_n;
   logic blankPin, keyScanStart, scanDoneFlag, dispFrameValid;
   logic keyScanDone = 1'b0;
   logic dispReady, dispBlank, frameBufReady;
   logic [KEY_BITS-1:0] keyState;
   fpsc_frame_t dispFrame;
   logic [4:0] scanWait = 5'h0;
   int nFail = 0, nTests = 0, nStart = 0, cycles = 0;

   // device drives the line only while its enable is low
   assign lineIn = (serDataOe_n === 1'b0) ? serDataOut : hostData;

   fpsc_cmd_port DUT (.clk(clk), .rst(rst), .serClkPin(serClk), .serDataIn(lineIn),
      .serDataOut(serDataOut), .serDataOe_n(serDataOe_n), .loadPin(load),
      .blankPin(blankPin), .keyScanStart(keyScanStart), .keyScanDone(keyScanDone),
      .keyState(keyState), .scanDoneFlag(scanDoneFlag), .dispFrame(dispFrame),
      .dispFrameValid(dispFrameValid), .dispReady(dispReady), .dispBlank(dispBlank),
      .frameBufReady(frameBufReady));

   fpsc_host_model host (.clk(clk), .lineIn(lineIn), .serClk(serClk),
      .hostData(hostData), .load(load));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // key scan circuit stand-in: done pulse 20 cycles after start
   always @(posedge clk) begin
      keyScanDone <= (scanWait == 5'h1);
      if (keyScanStart === 1'b1) begin
         nStart <= nStart + 1;
         scanWait <= 5'h14;
      end else if (scanWait != 5'h0) begin
         scanWait <= scanWait - 5'h1;
      end
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         nFail++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string w, input logic [41:0] e, input logic [41:0] g);
      nTests++;
      if (g !== e) begin
         nFail++;
         $display("wrong value %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chkb(input string w, input logic e, input logic g);
      chk(w, {41'h0, e}, {41'h0, g});
   endtask

   task automatic pop(input logic [41:0] e);
      chkb("frame valid", 1'b1, dispFrameValid);
      chk("frame", e, dispFrame);
      dispReady <= 1'b1;
      @(posedge clk);
      dispReady <= 1'b0;
      @(posedge clk);
   endtask

   // -----------------------------------------------
   // scenarios
   // -----------------------------------------------
   task automatic readout(input logic [44:0] v, input int n, input logic blk);
      logic [29:0] got;
      logic [29:0] keys;
      int s;
      keys = 30'h2155_5a5a ^ {26'h0, v[3:0]};
      s = nStart;
      keyState <= keys;
      host.send(v, n);
      host.strobe();
      chkb("line enable", 1'b0, serDataOe_n);
      chk("scan starts", 42'(s + 1), 42'(nStart));
      if (blk) begin
         blankPin <= 1'b1;
         repeat (100) @(posedge clk);
         chkb("blank held", 1'b0, dispBlank);
      end
      for (int i = 0; i < 100 && scanDoneFlag !== 1'b1; i++) @(posedge clk);
      chkb("scan done", 1'b1, scanDoneFlag);
      host.read(got);
      chk("key data", 42'(keys), 42'(got));
      host.strobe();
      chkb("line enable", 1'b1, serDataOe_n);
      chkb("scan done", 1'b0, scanDoneFlag);
      if (blk) begin
         for (int i = 0; i < BLANK_MAX_CYC && dispBlank !== 1'b1; i++) @(posedge clk);
         chkb("blank late", 1'b1, dispBlank);
      end
   endtask

   task automatic t_empty();
      int s;
      s = nStart;
      host.strobe();
      chkb("line enable", 1'b1, serDataOe_n);
      chkb("frame valid", 1'b0, dispFrameValid);
      chk("scan starts", 42'(s), 42'(nStart));
   endtask

   task automatic t_frames();
      host.send({41'h1c3_5a96_0f01, CMD_LOAD_A}, FRAME_A_BITS);
      host.strobe();
      chkb("line enable", 1'b1, serDataOe_n);
      pop({1'b0, 41'h1c3_5a96_0f01});
      // extra leading bit must fall away
      host.send({1'b1, 40'h96_0f3c_a5e1, CMD_LOAD_B}, FRAME_A_BITS);
      host.strobe();
      pop({1'b1, 40'h96_0f3c_a5e1, 1'b0});
      chkb("frame valid", 1'b0, dispFrameValid);
   endtask

   task automatic t_blank();
      blankPin <= 1'b1;
      for (int i = 0; i < BLANK_MAX_CYC && dispBlank !== 1'b1; i++) @(posedge clk);
      chkb("blank on", 1'b1, dispBlank);
      blankPin <= 1'b0;
      for (int i = 0; i < BLANK_MAX_CYC && dispBlank !== 1'b0; i++) @(posedge clk);
      chkb("blank off", 1'b0, dispBlank);
      readout({41'h0, 4'h4}, CMD_BITS, 1'b1);
   endtask

   task automatic t_bad();
      logic [3:0] codes [6];
      int s;
      codes = '{4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb};
      s = nStart;
      foreach (codes[k]) begin
         host.send({41'h1ff_ffff_ffff, codes[k]}, FRAME_A_BITS);
         host.strobe();
         chkb("frame valid", 1'b0, dispFrameValid);
         chkb("line enable", 1'b1, serDataOe_n);
      end
      chk("scan starts", 42'(s), 42'(nStart));
   endtask

   task automatic t_keys();
      logic [3:0] codes [6];
      codes = '{4'h4, 4'h5, 4'hc, 4'hd, 4'he, 4'hf};
      foreach (codes[k]) begin
         readout({41'h0a5_0f0f_3c3c, codes[k]}, FRAME_A_BITS, 1'b0);
         chkb("frame valid", 1'b0, dispFrameValid);
      end
      readout({41'h155_aaaa_0ff1, CMD_LOAD_A_KEY}, FRAME_A_BITS, 1'b0);
      pop({1'b0, 41'h155_aaaa_0ff1});
      readout({1'b0, 40'h3c_5a5a_c3c3, CMD_LOAD_B_KEY}, FRAME_B_BITS, 1'b0);
      pop({1'b1, 40'h3c_5a5a_c3c3, 1'b0});
   endtask

   // ninth frame meets a full buffer and is dropped
   task automatic t_fifo();
      for (int k = 0; k <= FIFO_DEPTH; k++) begin
         host.send({37'h0, k[3:0], CMD_LOAD_A}, FRAME_A_BITS);
         host.strobe();
      end
      chkb("buffer ready", 1'b0, frameBufReady);
      for (int k = 0; k < FIFO_DEPTH; k++) pop({38'h0, k[3:0]});
      chkb("frame valid", 1'b0, dispFrameValid);
      chkb("buffer ready", 1'b1, frameBufReady);
   endtask

   initial begin
      rst = 1'b1;
      blankPin = 1'b0;
      dispReady = 1'b0;
      keyState = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chkb("line enable", 1'b1, serDataOe_n);
      chkb("blank", 1'b1, dispBlank);
      chkb("scan done", 1'b0, scanDoneFlag);
      t_empty();
      t_frames();
      t_blank();
      t_bad();
      t_keys();
      t_empty();
      t_fifo();
      report_and_stop();
   end
endmodule
`default_nettype wire

/* rtl/fpsc_cmd_port.sv */
// Purpose: three-wire serial command port of a front-panel controller
// Assumes: serial clock, data, load strobe and blank are asynchronous pins
// Notes: display halves leave through an 8-word frame buffer
// Function
// RULE1: in input status sample data on each serial clock rise; reset into input.
// RULE2: load strobe rise takes last four shifted bits as command, msb first.
// RULE3: 0010/0011 load half A/B; 0110/0111 load the half and arm key output.
// RULE4: 010x, 110x, 111x select key output only, no display load.
// RULE5: any other command pattern does nothing.
// RULE6: host loads display data at least once before asking for keys.
// RULE7: strobe with no data shifted in is ignored.
// RULE8: output status only after a key command; data changes on clock rise.
// RULE9: strobe enters output status, next strobe returns to input status.
// RULE10: host keeps serial clock at or below 43 kHz; the bench host runs it at 6.25 MHz when sending.
// RULE11: blank change during valid period applied within 50 us.
// RULE12: blank change during invalid period waits until valid period begins.
// RULE13: scan-done high at scan end, low at next strobe rise.
// RULE14: key output is 30 bits, 1 means pressed.
// RULE15: half A frame 45 bits with lamp bit, half B 44 bits.
// RULE16: data line released on strobe rise returning to input status.
`timescale 1ns/1ps
`default_nettype none
module fpsc_cmd_port
   import fpsc_pkg::*;
#(
   parameter int KEYS = KEY_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic serClkPin,
   input wire logic serDataIn,
   output logic serDataOut,
   output logic serDataOe_n,
   input wire logic loadPin,
   input wire logic blankPin,
   output logic keyScanStart,
   input wire logic keyScanDone,
   input wire logic [KEYS-1:0] keyState,
   output logic scanDoneFlag,
   output fpsc_frame_t dispFrame,
   output logic dispFrameValid,
   input wire logic dispReady,
   output logic dispBlank,
   output logic frameBufReady
);

   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic serClkOld_q;
   logic loadOld_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
         serClkOld_q <= 1'b0;
         loadOld_q <= 1'b0;
      end else begin
         meta_q <= {blankPin, loadPin, serDataIn, serClkPin};
         sync_q <= meta_q;
         serClkOld_q <= sync_q[0];
         loadOld_q <= sync_q[2];
      end
   end

   logic clkRise;
   logic loadRise;
   logic dataBit;
   logic blankLvl;
   assign clkRise = sync_q[0] && !serClkOld_q;
   assign loadRise = sync_q[2] && !loadOld_q;
   assign dataBit = sync_q[1];
   assign blankLvl = sync_q[3];

   // --------------------------------------------------------------
   // input shifter
   // --------------------------------------------------------------
   fpsc_state_t state_q;
   logic [FRAME_A_BITS-1:0] shift_q;
   logic [5:0] bitCount_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_q <= '0;
         bitCount_q <= 6'h00;
      end else if (loadRise) begin
         bitCount_q <= 6'h00;
      end else if (clkRise && state_q == FPSC_ST_INPUT) begin
         shift_q <= {shift_q[FRAME_A_BITS-2:0], dataBit}; // RULE1
         if (bitCount_q != 6'h3f) begin
            bitCount_q <= bitCount_q + 6'h01;
         end
      end
   end

   // --------------------------------------------------------------
   // command decode
   // --------------------------------------------------------------
   logic [3:0] cmd;
   logic haveCmd;
   logic isLoadA;
   logic isLoadB;
   logic isKey;
   logic cmdTaken;

   assign cmd = shift_q[CMD_BITS-1:0]; // RULE2
   // fewer than a command's worth of bits counts as no data at all
   assign haveCmd = bitCount_q >= 6'(CMD_BITS); // RULE7
   assign isLoadA = (cmd == CMD_LOAD_A || cmd == CMD_LOAD_A_KEY) // RULE3
                    && bitCount_q >= 6'(FRAME_A_BITS); // RULE15
   assign isLoadB = (cmd == CMD_LOAD_B || cmd == CMD_LOAD_B_KEY) // RULE3
                    && bitCount_q >= 6'(FRAME_B_BITS); // RULE15
   assign isKey = cmd == CMD_LOAD_A_KEY || cmd == CMD_LOAD_B_KEY // RULE3
                  || cmd[3:1] == CMD_KEY_0 || cmd[3:1] == CMD_KEY_1
                  || cmd[3:1] == CMD_KEY_2; // RULE4 RULE5
   assign cmdTaken = loadRise && state_q == FPSC_ST_INPUT && haveCmd;

   // --------------------------------------------------------------
   // frame buffer toward the display
   // --------------------------------------------------------------
   fpsc_frame_t newFrame;
   logic pushFrame;

   always_comb begin
      newFrame.halfB = isLoadB;
      // half B has no lamp bit; the lamp position reads zero
      newFrame.bits = isLoadB ? {shift_q[FRAME_B_BITS-1:CMD_BITS], 1'b0}
                              : shift_q[FRAME_A_BITS-1:CMD_BITS];
   end

   // a full buffer drops the display part; key part still proceeds
   assign pushFrame = cmdTaken && (isLoadA || isLoadB);

   fpsc_fifo #(
      .WIDTH($bits(fpsc_frame_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_frameBuf (
      .clk(clk),
      .rst(rst),
      .inValid(pushFrame),
      .inReady(frameBufReady),
      .inData(newFrame),
      .outValid(dispFrameValid),
      .outReady(dispReady),
      .outData(dispFrame)
   );

   // --------------------------------------------------------------
   // input / output status
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= FPSC_ST_INPUT; // RULE1
      end else if (loadRise) begin
         unique case (state_q)
            FPSC_ST_INPUT: begin
               if (cmdTaken && isKey) begin
                  state_q <= FPSC_ST_OUTPUT; // RULE8 RULE9
               end
            end
            FPSC_ST_OUTPUT: begin
               state_q <= FPSC_ST_INPUT; // RULE9
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         keyScanStart <= 1'b0;
      end else begin
         keyScanStart <= cmdTaken && isKey;
      end
   end

   // --------------------------------------------------------------
   // key readout
   // --------------------------------------------------------------
   logic [KEYS-1:0] keyShift_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         keyShift_q <= '0;
         serDataOut <= 1'b0;
      end else if (keyScanDone) begin
         keyShift_q <= keyState; // RULE14
      end else if (clkRise && state_q == FPSC_ST_OUTPUT) begin
         serDataOut <= keyShift_q[KEYS-1]; // RULE8
         keyShift_q <= {keyShift_q[KEYS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         serDataOe_n <= 1'b1;
      end else if (loadRise && state_q == FPSC_ST_OUTPUT) begin
         serDataOe_n <= 1'b1; // RULE16
      end else if (cmdTaken && isKey) begin
         serDataOe_n <= 1'b0;
      end
   end

   // scan end wins over a strobe in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         scanDoneFlag <= 1'b0;
      end else if (keyScanDone) begin
         scanDoneFlag <= 1'b1; // RULE13
      end else if (loadRise) begin
         scanDoneFlag <= 1'b0; // RULE13
      end
   end

   // --------------------------------------------------------------
   // blanking
   // --------------------------------------------------------------
   logic blankValid;
   logic blankApplied_q;
   logic shownOnce_q;

   // a frame in flight or a readout is the invalid period
   assign blankValid = state_q == FPSC_ST_INPUT && bitCount_q == 6'h00;

   always_ff @(posedge clk) begin
      if (rst) begin
         blankApplied_q <= 1'b1;
      end else if (blankValid) begin
         blankApplied_q <= blankLvl; // RULE11 RULE12
      end
   end

   // display stays dark until the first half has been loaded
   always_ff @(posedge clk) begin
      if (rst) begin
         shownOnce_q <= 1'b0;
      end else if (pushFrame && frameBufReady) begin
         shownOnce_q <= 1'b1;
      end
   end

   assign dispBlank = blankApplied_q || !shownOnce_q;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   logic [15:0] blankWait_q;

   always_ff @(posedge clk) begin
      if (rst || !blankValid || blankApplied_q == blankLvl) begin
         blankWait_q <= 16'h0000;
      end else begin
         blankWait_q <= blankWait_q + 16'h0001;
      end
   end

   chk_blank_delay: assert property (@(posedge clk) disable iff (rst) // RULE11
      blankWait_q < 16'(BLANK_MAX_CYC)) else $error("blank change applied too late");

   chk_blank_hold: assert property (@(posedge clk) disable iff (rst) // RULE12
      !blankValid |=> $stable(blankApplied_q)) else $error("blank changed while invalid");

   chk_out_entry: assert property (@(posedge clk) disable iff (rst) // RULE8
      $rose(state_q) |-> $past(cmdTaken) && $past(isKey))
      else $error("output status without key command");

   chk_out_return: assert property (@(posedge clk) disable iff (rst) // RULE9
      state_q == FPSC_ST_OUTPUT && loadRise |=> state_q == FPSC_ST_INPUT && serDataOe_n)
      else $error("strobe did not end readout");

   chk_release_line: assert property (@(posedge clk) disable iff (rst) // RULE16
      state_q == FPSC_ST_INPUT && !(cmdTaken && isKey) |=> serDataOe_n)
      else $error("data line driven in input status");

   chk_short_ignore: assert property (@(posedge clk) disable iff (rst) // RULE7
      loadRise && bitCount_q < 6'(CMD_BITS) && state_q == FPSC_ST_INPUT
      |=> state_q == FPSC_ST_INPUT && !keyScanStart) else $error("empty strobe acted");

   chk_bad_code: assert property (@(posedge clk) disable iff (rst) // RULE5
      cmdTaken && cmd inside {4'h0, 4'h1, 4'h8, 4'h9, 4'ha, 4'hb} |-> !pushFrame
      ##1 !keyScanStart && state_q == FPSC_ST_INPUT) else $error("prohibited code acted");

   chk_half_a: assert property (@(posedge clk) disable iff (rst) // RULE3
      cmdTaken && cmd == CMD_LOAD_A && bitCount_q >= 6'(FRAME_A_BITS)
      |-> pushFrame && !newFrame.halfB) else $error("half A not loaded");

   chk_scan_flag: assert property (@(posedge clk) disable iff (rst) // RULE13
      keyScanDone || (scanDoneFlag && !loadRise) |=> scanDoneFlag)
      else $error("scan-done flag wrong");
   chk_scan_clear: assert property (@(posedge clk) disable iff (rst) // RULE13
      loadRise && !keyScanDone |=> !scanDoneFlag) else $error("scan-done flag not cleared");

   chk_sample_edge: assert property (@(posedge clk) disable iff (rst) // RULE1
      clkRise && state_q == FPSC_ST_INPUT && !loadRise |=> shift_q[0] == $past(dataBit))
      else $error("input bit not sampled");

endmodule
`default_nettype wire

/* rtl/fpsc_fifo.sv */
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, DEPTH a power of two
// Notes: full and empty come from pointers carrying one extra wrap bit
`timescale 1ns/1ps
`default_nettype none
module fpsc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;

   assign inReady = (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]) || (wrPtr_q[AW] == rdPtr_q[AW]);
   assign outValid = wrPtr_q != rdPtr_q;
   assign outData = mem[rdPtr_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (inValid && inReady) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_q <= '0;
      end else if (inValid && inReady) begin
         wrPtr_q <= wrPtr_q + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdPtr_q <= '0;
      end else if (outValid && outReady) begin
         rdPtr_q <= rdPtr_q + (AW+1)'(1);
      end
   end

endmodule
`default_nettype wire

/* rtl/fpsc_pkg.sv */
// Purpose: shared constants and types of the front-panel serial command port
// Assumes: 50 MHz core clock; serial pins arrive asynchronously
// Notes: command codes are sent most significant bit first
package fpsc_pkg;

   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int BLANK_MAX_US = 50;
   // longest time, so rounded down
   localparam int BLANK_MAX_CYC = (BLANK_MAX_US * 1000) / CLK_PERIOD_NS;

   // --------------------------------------------------------------
   // frame layout
   // --------------------------------------------------------------
   localparam int CMD_BITS = 4;
   localparam int LCD_BITS = 40;
   localparam int LAMP_BITS = 1;
   localparam int FRAME_A_BITS = LCD_BITS + LAMP_BITS + CMD_BITS;
   localparam int FRAME_B_BITS = LCD_BITS + CMD_BITS;
   localparam int KEY_BITS = 30;
   localparam int FIFO_DEPTH = 8;

   // --------------------------------------------------------------
   // command codes, bit 3 is commandBitMsb, bit 0 commandBitLsb
   // --------------------------------------------------------------
   localparam logic [3:0] CMD_LOAD_A = 4'h2;
   localparam logic [3:0] CMD_LOAD_B = 4'h3;
   localparam logic [3:0] CMD_LOAD_A_KEY = 4'h6;
   localparam logic [3:0] CMD_LOAD_B_KEY = 4'h7;
   localparam logic [2:0] CMD_KEY_0 = 3'h2;
   localparam logic [2:0] CMD_KEY_1 = 3'h6;
   localparam logic [2:0] CMD_KEY_2 = 3'h7;

   typedef enum logic [0:0] {
      FPSC_ST_INPUT = 1'b0,
      FPSC_ST_OUTPUT = 1'b1
   } fpsc_state_t;

   // one display half as it travels through the frame buffer
   typedef struct packed {
      logic halfB;
      logic [LCD_BITS+LAMP_BITS-1:0] bits;
   } fpsc_frame_t;

endpackage
